// ==== rx_line_input_select.sv ====
/*
  Receive line input selector: picks the analog, dual-rail or optical receive
  path, recovers the bit clock (optical NRZ uses its clock pin), applies polarity
  (dual-rail and optical paths only) and line decoding, and hands decoded bits
  through a two-entry buffer.
  Assumes all line pins are asynchronous to clk_i and that the consumer of the
  bit stream is on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_line_input_select
  import rx_line_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  // Line pins
  input wire logic rx_analog_line_a_i,
  input wire logic rx_analog_line_b_i,
  input wire logic rx_pos_rail_in_i,
  input wire logic rx_neg_rail_in_i,
  input wire logic rx_optical_data_in_i,
  input wire logic rx_optical_clock_in_i,
  // Decoded bit stream
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  input wire logic rx_bit_ready_i
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [CNT_W-1:0] bit_period(input logic t1);
    bit_period = t1 ? T1_BIT_CYC : E1_BIT_CYC;
  endfunction

  state_s st_r;
  state_s st_nxt;

  logic [NPINS-1:0] pins;
  path_e path;
  logic pol_low;
  logic rail_a;
  logic rail_b;
  logic rail_a_prev;
  logic rail_b_prev;
  logic mark_rise;
  logic odata;
  logic odata_prev;
  logic oclk_fall;
  logic is_cmi;
  logic is_nrz;
  logic [CNT_W-1:0] per;
  logic [CNT_W-1:0] q1;
  logic [CNT_W-1:0] q3;
  logic [CNT_W-1:0] half;
  logic [DATA_W-1:0] status_word;
  logic bit_vld;
  logic bit_val;
  logic bound;
  logic in_ready;
  logic mark;
  logic pol;
  logic viol;
  logic zs;

  assign pins[PIN_POS] = rx_pos_rail_in_i;
  assign pins[PIN_NEG] = rx_neg_rail_in_i;
  assign pins[PIN_ODATA] = rx_optical_data_in_i;
  assign pins[PIN_OCLK] = rx_optical_clock_in_i;
  assign pins[PIN_ANA_A] = rx_analog_line_a_i;
  assign pins[PIN_ANA_B] = rx_analog_line_b_i;

  // ----------------------------------------
  // Path and polarity
  // ----------------------------------------
  // path choice
  // rail code bit unused in analog
  assign path = !st_r.cfg_act.sel ? PATH_ANALOG :
                st_r.cfg_act.code[1] ? PATH_DUAL : PATH_OPTICAL;

  // reset value of zero means active low
  assign pol_low = ~st_r.cfg_act.inv;

  // digital pins not looked at in analog
  assign rail_a = (path == PATH_ANALOG) ? st_r.s2[PIN_ANA_A] : st_r.s2[PIN_POS] ^ pol_low;
  assign rail_b = (path == PATH_ANALOG) ? st_r.s2[PIN_ANA_B] : st_r.s2[PIN_NEG] ^ pol_low;
  assign rail_a_prev = (path == PATH_ANALOG) ? st_r.s3[PIN_ANA_A] : st_r.s3[PIN_POS] ^ pol_low;
  assign rail_b_prev = (path == PATH_ANALOG) ? st_r.s3[PIN_ANA_B] : st_r.s3[PIN_NEG] ^ pol_low;
  assign mark_rise = (rail_a & ~rail_a_prev) | (rail_b & ~rail_b_prev);

  assign odata = st_r.s2[PIN_ODATA] ^ pol_low;
  assign odata_prev = st_r.s3[PIN_ODATA] ^ pol_low;
  // falling edge of the optical clock
  assign oclk_fall = st_r.s3[PIN_OCLK] & ~st_r.s2[PIN_OCLK];

  assign is_cmi = (path == PATH_OPTICAL) && (st_r.cfg_act.code == CODE_CMI);
  assign is_nrz = (path == PATH_OPTICAL) && (st_r.cfg_act.code == CODE_NRZ);

  // Bit period follows the rate bit; integer division keeps the DPLL slightly fast
  assign per = bit_period(st_r.cfg_act.t1);
  assign q1 = per >> DPLL_Q_SHIFT;
  assign q3 = per - q1;
  assign half = per >> DPLL_H_SHIFT;

  assign status_word = DATA_W'({st_r.ovf, st_r.bpv, path});

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    bit_vld = 1'b0;
    bit_val = 1'b0;
    in_ready = 1'b0;
    mark = 1'b0;
    pol = 1'b0;
    viol = 1'b0;
    zs = 1'b0;

    // Two-stage synchronisers, third stage for edges
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // Register port; clears come first so a same-cycle event wins
    st_nxt.rdata = '0;
    if (wr_i) begin
      if (addr_i == CTRL_ADDR) begin
        st_nxt.cfg = cfg_s'(wr_data_i[CFG_W-1:0]);
      end else if (addr_i == STAT_ADDR) begin
        if (wr_data_i[STAT_BPV_BIT]) begin
          st_nxt.bpv = 1'b0;
        end
        if (wr_data_i[STAT_OVF_BIT]) begin
          st_nxt.ovf = 1'b0;
        end
      end
    end
    if (rd_i) begin
      if (addr_i == CTRL_ADDR) begin
        st_nxt.rdata = DATA_W'(st_r.cfg);
      end else if (addr_i == STAT_ADDR) begin
        st_nxt.rdata = status_word;
      end else begin
        st_nxt.rdata = '0;
      end
    end

    // DPLL phase counter, free running between corrections
    if (st_r.phase >= per - PHASE_ONE) begin
      st_nxt.phase = PHASE_ZERO;
    end else begin
      st_nxt.phase = st_r.phase + PHASE_ONE;
    end
    // rail pulse marks the bit start
    if (path != PATH_OPTICAL && mark_rise) begin
      st_nxt.phase = PHASE_ZERO;
    end
    // CMI edges pull the phase to the nearest half-bit
    if (is_cmi && (odata != odata_prev)) begin
      if (st_r.phase >= q1 && st_r.phase < q3) begin
        st_nxt.phase = half;
      end else begin
        st_nxt.phase = PHASE_ZERO;
      end
    end

    // new mode only at a bit boundary
    bound = (st_nxt.phase == PHASE_ZERO);
    if (bound) begin
      st_nxt.cfg_act = st_r.cfg;
    end

    case (path)
      PATH_ANALOG, PATH_DUAL: begin
        // rails sampled mid-pulse on recovered clock
        if (st_r.phase == q1) begin
          mark = rail_a | rail_b;
          pol = rail_b;
          viol = mark && st_r.mark_seen && (pol == st_r.last_pol);
          zs = (path == PATH_ANALOG) ? st_r.cfg_act.code[0] : (st_r.cfg_act.code == CODE_ZS);
          bit_vld = 1'b1;
          // A violation is a substitution marker in zero-substitution code
          bit_val = mark && !(zs && viol);
          if (viol && !zs) begin
            st_nxt.bpv = 1'b1;
          end
          if (mark) begin
            st_nxt.last_pol = pol;
            st_nxt.mark_seen = 1'b1;
          end
        end
      end
      PATH_OPTICAL: begin
        if (is_nrz) begin
          if (oclk_fall) begin
            bit_vld = 1'b1;
            bit_val = odata;
          end
        end else begin
          // optical clock not used for CMI
          if (st_r.phase == q1) begin
            st_nxt.half_a = odata;
          end
          if (st_r.phase == q3) begin
            bit_vld = 1'b1;
            bit_val = (st_r.half_a == odata);
          end
        end
      end
      default: begin
        bit_vld = 1'b0;
      end
    endcase

    // Two-entry buffer; the line cannot be stalled, so a full buffer drops and flags
    if (st_r.buf_vld[0] && rx_bit_ready_i) begin
      st_nxt.buf_data[0] = st_r.buf_data[1];
      st_nxt.buf_vld[0] = st_r.buf_vld[1];
      st_nxt.buf_vld[1] = 1'b0;
    end
    in_ready = !st_nxt.buf_vld[1];
    if (bit_vld) begin
      if (!in_ready) begin
        st_nxt.ovf = 1'b1;
      end else if (!st_nxt.buf_vld[0]) begin
        st_nxt.buf_data[0] = bit_val;
        st_nxt.buf_vld[0] = 1'b1;
      end else begin
        st_nxt.buf_data[1] = bit_val;
        st_nxt.buf_vld[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o = st_r.rdata;
  assign rx_bit_o = st_r.buf_data[0];
  assign rx_bit_valid_o = st_r.buf_vld[0];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  property p_analog_src;
    (path == PATH_ANALOG && bit_vld && bit_val) |-> (st_r.s2[PIN_ANA_A] | st_r.s2[PIN_ANA_B]);
  endproperty
  a_analog_src: assert property (p_analog_src) else $error("analog mark without analog input");

  property p_dual_src;
    (path == PATH_DUAL && bit_vld && bit_val) |->
      ((st_r.s2[PIN_POS] ^ pol_low) | (st_r.s2[PIN_NEG] ^ pol_low));
  endproperty
  a_dual_src: assert property (p_dual_src) else $error("dual-rail mark without active rail");

  property p_dual_time;
    (path == PATH_DUAL && bit_vld) |-> (st_r.phase == q1);
  endproperty
  a_dual_time: assert property (p_dual_time) else $error("dual-rail bit off recovered phase");

  property p_realign;
    (path == PATH_DUAL && mark_rise) |=> (st_r.phase == PHASE_ZERO) ##1 (st_r.phase == PHASE_ONE);
  endproperty
  a_realign: assert property (p_realign) else $error("DPLL did not lock to rail pulse");

  property p_cmi_time;
    (is_cmi && bit_vld) |-> (st_r.phase == q3) && !(oclk_fall && st_r.phase != q3);
  endproperty
  a_cmi_time: assert property (p_cmi_time) else $error("CMI bit not from recovered phase");

  property p_opt_edge;
    (is_nrz && bit_vld) |-> (st_r.s3[PIN_OCLK] && !st_r.s2[PIN_OCLK] && bit_val == odata);
  endproperty
  a_opt_edge: assert property (p_opt_edge) else $error("optical bit not on falling clock");

  property p_cfg_hold;
    !bound |=> $stable(st_r.cfg_act);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("mode changed inside a bit");

  property p_buf_hold;
    (rx_bit_valid_o && !rx_bit_ready_i) |=> (rx_bit_valid_o && $stable(rx_bit_o));
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("stalled bit lost");

  property p_ctrl_read;
    (rd_i && addr_i == CTRL_ADDR && !wr_i) |=> (rd_data_o == DATA_W'(st_r.cfg)) ##1 (rd_data_o == '0 || $past(rd_i));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read back wrong");

endmodule

`default_nettype wire

// ==== rx_line_pkg.sv ====
/*
  Constants, field layouts and state types for the receive line input selector.
  Assumes a 100 MHz system clock and a plain one-cycle register port.
*/
`default_nettype none

package rx_line_pkg;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h01;

  // Status word bit positions
  localparam int STAT_BPV_BIT = 2;
  localparam int STAT_OVF_BIT = 3;

  // ----------------------------------------
  // Line codes of the two-bit code field
  // ----------------------------------------
  localparam logic [1:0] CODE_NRZ = 2'h0;
  localparam logic [1:0] CODE_CMI = 2'h1;
  localparam logic [1:0] CODE_AMI = 2'h2;
  localparam logic [1:0] CODE_ZS = 2'h3;

  // Control register layout, bit 4 down to bit 0
  typedef struct packed {
    logic t1;
    logic inv;
    logic sel;
    logic [1:0] code;
  } cfg_s;
  localparam int CFG_W = $bits(cfg_s);

  typedef enum logic [1:0] {PATH_ANALOG, PATH_DUAL, PATH_OPTICAL} path_e;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int E1_RATE_KBPS = 2048;
  localparam int T1_RATE_KBPS = 1544;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] E1_BIT_CYC = CNT_W'(CLK_FREQ_KHZ / E1_RATE_KBPS);
  localparam logic [CNT_W-1:0] T1_BIT_CYC = CNT_W'(CLK_FREQ_KHZ / T1_RATE_KBPS);
  localparam logic [CNT_W-1:0] PHASE_ONE = 7'h01;
  localparam logic [CNT_W-1:0] PHASE_ZERO = 7'h00;
  localparam int DPLL_Q_SHIFT = 2;
  localparam int DPLL_H_SHIFT = 1;

  // ----------------------------------------
  // Pin sample vector
  // ----------------------------------------
  localparam int NPINS = 6;
  localparam int PIN_POS = 0;
  localparam int PIN_NEG = 1;
  localparam int PIN_ODATA = 2;
  localparam int PIN_OCLK = 3;
  localparam int PIN_ANA_A = 4;
  localparam int PIN_ANA_B = 5;

  typedef struct packed {
    logic [NPINS-1:0] s1;
    logic [NPINS-1:0] s2;
    logic [NPINS-1:0] s3;
    cfg_s cfg;
    cfg_s cfg_act;
    logic [CNT_W-1:0] phase;
    logic half_a;
    logic mark_seen;
    logic last_pol;
    logic bpv;
    logic ovf;
    logic [1:0] buf_data;
    logic [1:0] buf_vld;
    logic [DATA_W-1:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '0;

endpackage

`default_nettype wire

// ==== rx_line_partner.sv ====
/*
  Line-side model of the receive selector: drives the analog, dual-rail and
  optical pins with whole frames.
  Assumes a 480 ns bit period for rail and CMI frames, which matches the E1 recovery of the design.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_line_partner (
  // Line pins
  output logic ana_a_o,
  output logic ana_b_o,
  output logic pos_o,
  output logic neg_o,
  output logic odata_o,
  output logic oclk_o
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  logic last_r;
  initial begin
    {ana_a_o, ana_b_o, odata_o, oclk_o} = 4'h0;
    {pos_o, neg_o} = 2'h3;
    last_r = 1'b0;
  end

  // ----------------------------------------
  // Rail frames
  // ----------------------------------------
  // alternating marks on rails
  task automatic send_rail(input logic [15:0] w, input logic ana, input logic hi, input int viol,
                           input logic noise);
    logic p;
    {pos_o, neg_o} = {2{~hi}};
    #960;
    for (int i = 15; i >= 0; i--) begin
      p = (i == viol) ? last_r : ~last_r;
      if (w[i]) last_r = p;
      if (ana) {ana_a_o, ana_b_o} = {w[i] & p, w[i] & ~p};
      // Noise on digital pins only when the analog path is chosen
      if (!ana) {pos_o, neg_o} = {(w[i] & p) ^ ~hi, (w[i] & ~p) ^ ~hi};
      else if (noise) {pos_o, neg_o} = ~{pos_o, neg_o};
      #240;
      {ana_a_o, ana_b_o} = 2'h0;
      if (!ana) {pos_o, neg_o} = {2{~hi}};
      else if (noise) {pos_o, neg_o} = ~{pos_o, neg_o};
      #240;
    end
    {pos_o, neg_o} = {2{~hi}};
    #960;
  endtask

  // ----------------------------------------
  // Optical frames
  // ----------------------------------------
  // clock runs only within frame
  // far end clock, bench runs it at 125 ns
  task automatic send_nrz(input logic [15:0] w, input logic hi);
    for (int i = 15; i >= 0; i--) begin
      oclk_o = 1'b1;
      #31.25;
      // Data moves after the rising edge, so a rising-edge sampler reads stale bits
      odata_o = w[i] ^ ~hi;
      #31.25;
      oclk_o = 1'b0;
      #62.5;
    end
  endtask

  // one code bit each 480 ns
  task automatic send_cmi(input logic [15:0] w, input logic noise);
    for (int i = 15; i >= 0; i--) begin
      if (w[i]) last_r = ~last_r;
      for (int h = 0; h < 4; h++) begin
        if (h == 0) odata_o = w[i] ? last_r : 1'b0;
        if (h == 2) odata_o = w[i] ? last_r : 1'b1;
        if (noise) oclk_o = ~oclk_o;
        #120;
      end
    end
  endtask
endmodule

`default_nettype wire

// ==== tb_rx_line_input_select.sv ====
/*
  Self-checking bench of the receive line input selector.
  Assumes the line model drives all pins and the bench owns the register port.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_rx_line_input_select
  import rx_line_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [15:0] WORD = 16'hB5A7;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ready = 1'b1;
  logic [DATA_W-1:0] rdata;
  logic rx_bit;
  logic rx_valid;
  logic ana_a, ana_b, pos, neg, odata, oclk;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic q[$];

  always #5 clk = ~clk;

  rx_line_input_select DUT (.clk_i(clk), .reset_i(reset), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdata), .rx_analog_line_a_i(ana_a), .rx_analog_line_b_i(ana_b),
    .rx_pos_rail_in_i(pos), .rx_neg_rail_in_i(neg), .rx_optical_data_in_i(odata),
    .rx_optical_clock_in_i(oclk), .rx_bit_o(rx_bit), .rx_bit_valid_o(rx_valid), .rx_bit_ready_i(ready));

  rx_line_partner line (.ana_a_o(ana_a), .ana_b_o(ana_b), .pos_o(pos), .neg_o(neg), .odata_o(odata),
    .oclk_o(oclk));

  // ----------------------------------------
  // Consumer and watchdog
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1 && ready === 1'b1) q.push_back(rx_bit);
    if (cyc == 30000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic check8(input string name, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic chk_reg(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] m,
                         input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check8(name, e, rdata & m);
  endtask

  // Searching the stream tolerates free-running bits before and after a frame
  task automatic check_seq(input string name, input logic [11:0] e);
    logic hit;
    logic [11:0] w;
    hit = 1'b0;
    for (int s = 0; s + 12 <= q.size(); s++) begin
      w = '0;
      for (int k = 0; k < 12; k++) w = {w[10:0], q[s+k]};
      if (w === e) hit = 1'b1;
    end
    n_checks++;
    if (hit !== 1'b1) begin
      errors++;
      $display("mismatch %s expected %h seen absent", name, e);
    end
  endtask

  // New control lands at a bit boundary; wait well past one, then start clean
  task automatic cfg(input logic [7:0] d);
    wr_reg(CTRL_ADDR, d);
    repeat (100) @(posedge clk);
    wr_reg(STAT_ADDR, 8'h0C);
    q.delete();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check8("valid", 8'h00, {7'h00, rx_valid});
    chk_reg("ctrl", CTRL_ADDR, 8'hFF, 8'h00);
    chk_reg("status", STAT_ADDR, 8'hFF, 8'h00);
    chk_reg("unmapped", 8'h7F, 8'hFF, 8'h00);
    wr_reg(CTRL_ADDR, 8'hFF);
    chk_reg("ctrl_rw", CTRL_ADDR, 8'hFF, 8'h1F);
    $display("test reset done");
  endtask

  task automatic t_analog();
    cfg(8'h02);
    chk_reg("path_ana", STAT_ADDR, 8'h03, 8'h00);
    line.send_rail(WORD, 1'b1, 1'b0, -1, 1'b1);
    repeat (20) @(posedge clk);
    check_seq("analog", WORD[11:0]);
    $display("test analog done");
  endtask

  task automatic t_dual();
    cfg(8'h06);
    chk_reg("path_dual", STAT_ADDR, 8'h03, 8'h01);
    line.send_rail(WORD, 1'b0, 1'b0, -1, 1'b0);
    repeat (20) @(posedge clk);
    check_seq("dual_low", WORD[11:0]);
    cfg(8'h0E);
    line.send_rail(WORD, 1'b0, 1'b1, -1, 1'b0);
    repeat (20) @(posedge clk);
    check_seq("dual_high", WORD[11:0]);
    $display("test dual done");
  endtask

  task automatic t_codes();
    cfg(8'h06);
    line.send_rail(WORD, 1'b0, 1'b0, 2, 1'b0);
    chk_reg("bpv", STAT_ADDR, 8'h04, 8'h04);
    wr_reg(STAT_ADDR, 8'h04);
    chk_reg("bpv_clr", STAT_ADDR, 8'h04, 8'h00);
    cfg(8'h07);
    line.send_rail(WORD, 1'b0, 1'b0, 2, 1'b0);
    repeat (20) @(posedge clk);
    check_seq("zero_sub", WORD[11:0] & 12'hFFB);
    $display("test codes done");
  endtask

  task automatic t_optical();
    cfg(8'h04);
    chk_reg("path_opt", STAT_ADDR, 8'h03, 8'h02);
    line.send_nrz(WORD, 1'b0);
    repeat (20) @(posedge clk);
    check_seq("nrz_low", WORD[11:0]);
    cfg(8'h0C);
    line.send_nrz(WORD, 1'b1);
    repeat (20) @(posedge clk);
    check_seq("nrz_high", WORD[11:0]);
    cfg(8'h14);
    line.send_nrz(WORD, 1'b0);
    repeat (20) @(posedge clk);
    check_seq("nrz_t1", WORD[11:0]);
    cfg(8'h05);
    line.send_cmi(WORD, 1'b1);
    repeat (80) @(posedge clk);
    check_seq("cmi", WORD[11:0]);
    $display("test optical done");
  endtask

  task automatic t_stall();
    cfg(8'h06);
    ready <= 1'b0;
    line.send_rail(WORD, 1'b0, 1'b0, -1, 1'b0);
    @(negedge clk);
    check8("held", 8'h01, {7'h00, rx_valid});
    chk_reg("ovf", STAT_ADDR, 8'h08, 8'h08);
    @(posedge clk);
    ready <= 1'b1;
    // Optical NRZ without a clock makes no bits, so the buffer can empty
    cfg(8'h04);
    @(negedge clk);
    check8("drained", 8'h00, {7'h00, rx_valid});
    chk_reg("ovf_clr", STAT_ADDR, 8'h08, 8'h00);
    $display("test stall done");
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_reset();
    t_analog();
    t_dual();
    t_codes();
    t_optical();
    t_stall();
    tally_and_finish();
  end
endmodule

`default_nettype wire
